// file: src/stcs_map.vh
// constants for the split timer control and status block
// assumes a 32-bit apb bus, byte addressing, one register per aligned word
//
// Function
// (R1) low match flag sets when low counter becomes equal to low compare value
// (R2) low match flag clears only by reading it as 1 then writing 0
// (R3) low wrap flag sets when low counter wraps from FF to 00
// (R4) low wrap flag clears by reading it set then writing 0
// (R5) low clear control 0 means low match never resets low counter
// (R6) low overflow interrupt enable 1 requests interrupt on low overflow
// (R7) high clear control 0 in 16-bit mode never clears combined counter on match
// (R8) 8-bit mode with high clear selected resets high counter on high match
// (R9) high match flag clears by reading it as 1 then writing 0
// (R10) high wrap flag clears by reading it as 1 then writing 0
// (R11) high overflow interrupt enable requests interrupt on high overflow
// (R12) control bits and flags reset to 0; request only while flag and enable; code registers requests, so they lag flag and enable by one clock
`ifndef STCS_MAP_VH
`define STCS_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define STCS_ADDR_W      8
`define STCS_OFF_CTRL    8'h00
`define STCS_OFF_FLAGS   8'h04
`define STCS_OFF_CNT     8'h08
`define STCS_OFF_CMP     8'h0C
`define STCS_OFF_ISTAT   8'h10
`define STCS_OFF_ICLR    8'h14
`define STCS_OFF_IEN     8'h18

// ----------------------------------------
// control register fields
// ----------------------------------------
`define STCS_CTRL_W      6
`define STCS_CTRL_RST    6'h00
`define STCS_CTRL_CLRL   0
`define STCS_CTRL_OVIEL  1
`define STCS_CTRL_CLRH   2
`define STCS_CTRL_OVIEH  3
`define STCS_CTRL_MODE16 4
`define STCS_CTRL_RUN    5

// ----------------------------------------
// flag / event layout (flags, istat, iclr, ien share it)
// ----------------------------------------
`define STCS_NFLAG       4
`define STCS_FLAG_RST    4'h0
`define STCS_F_LMATCH    0
`define STCS_F_LWRAP     1
`define STCS_F_HMATCH    2
`define STCS_F_HWRAP     3

// ----------------------------------------
// counter and compare values
// ----------------------------------------
`define STCS_HALF_MAX    8'hFF
`define STCS_HALF_ZERO   8'h00
`define STCS_HALF_ONE    8'h01
`define STCS_CNT_RST     16'h0000
`define STCS_CMP_RST     16'hFFFF
`define STCS_DATA_ZERO   32'h00000000
`define STCS_CMP_LO_RST  8'hFF
`define STCS_CMP_HI_RST  8'hFF

// ----------------------------------------
// counter and compare word fields
// ----------------------------------------
`define STCS_LO_BITS     7:0
`define STCS_HI_BITS     15:8
`define STCS_CNT_BITS    15:0

`endif

// file: src/stcs_flag.v
// one software-cleared event flag with read-then-write-zero clear
// assumes the caller gives single-cycle pulses on the bus completion edge
module stcs_flag (
  input  wire clk,
  input  wire rst_n,
  input  wire set_pulse,
  input  wire rd_as_one,
  input  wire wr_access,
  input  wire wr_bit,
  output reg  flag_reg
);

  reg armed_reg;
  reg armed_next;
  reg flag_next;

  // ----------------------------------------
  // clear sequence and set priority
  // ----------------------------------------
  // any write ends the arming, so a stale read cannot clear a later event
  always @* begin
    flag_next  = flag_reg;
    armed_next = armed_reg;
    if (rd_as_one) begin
      armed_next = 1'b1;
    end
    if (wr_access) begin
      armed_next = 1'b0;
      if (armed_reg && !wr_bit) begin
        flag_next = 1'b0; // R2 R4 R9 R10
      end
    end
    // a new event wins over a clear in the same cycle
    if (set_pulse) begin
      flag_next = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg  <= 1'b0; // R12
      armed_reg <= 1'b0;
    end else begin
      flag_reg  <= flag_next;
      armed_reg <= armed_next;
    end
  end

endmodule // stcs_flag

// file: src/stcs_top.v
// split timer: one 16-bit counter or two 8-bit halves, with flags and apb
// assumes count_tick is a one-cycle strobe made by a prescaler on clk
`include "stcs_map.vh"

module stcs_top (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        count_tick,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  output reg         low_ovf_irq,
  output reg         high_ovf_irq
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg  [`STCS_CTRL_W-1:0]  ctrl_reg;
  reg  [`STCS_CTRL_W-1:0]  ctrl_next;
  reg  [7:0]               low_half_counter_reg;
  reg  [7:0]               low_half_counter_next;
  reg  [7:0]               high_half_counter_reg;
  reg  [7:0]               high_half_counter_next;
  reg  [7:0]               low_half_compare_value_reg;
  reg  [7:0]               high_half_compare_value_reg;
  reg  [`STCS_NFLAG-1:0]   istat_reg;
  reg  [`STCS_NFLAG-1:0]   istat_next;
  reg  [`STCS_NFLAG-1:0]   ien_reg;
  reg  [`STCS_NFLAG-1:0]   event_vec;
  reg  [31:0]              rdata_next;
  reg                      addr_ok;
  reg                      low_match_ev;
  reg                      low_wrap_ev;
  reg                      high_match_ev;
  reg                      high_wrap_ev;
  reg                      low_eq;
  reg                      high_eq;
  reg                      comb_eq;
  reg                      low_at_max;
  reg                      high_at_max;
  reg                      comb_at_max;
  reg                      low_ovf_irq_next;
  reg                      high_ovf_irq_next;
  reg                      irq_next;
  wire [15:0]              combined_16bit_counter;
  wire [15:0]              comb_inc;
  wire [`STCS_NFLAG-1:0]   flag_vec;
  wire                     setup_ph;
  wire                     done;
  wire                     wr_done;
  wire                     rd_done;
  wire                     mode16;
  wire                     tick;
  wire                     wr_ctrl;
  wire                     wr_flags;
  wire                     wr_cnt;
  wire                     wr_cmp;
  wire                     wr_iclr;
  wire                     wr_ien;
  wire                     rd_flags;

  assign combined_16bit_counter = {high_half_counter_reg, low_half_counter_reg};
  assign comb_inc = combined_16bit_counter + 16'h0001;
  assign mode16   = ctrl_reg[`STCS_CTRL_MODE16];
  assign tick     = count_tick & ctrl_reg[`STCS_CTRL_RUN];

  // ----------------------------------------
  // apb slave phases
  // ----------------------------------------
  // pready rises one cycle after setup, so every access has one wait-free access cycle
  assign setup_ph = psel & ~penable;
  assign done     = psel & penable & pready;
  assign wr_done  = done & pwrite & ~pslverr;
  assign rd_done  = done & ~pwrite & ~pslverr;

  // ----------------------------------------
  // register strobes
  // ----------------------------------------
  // decoded once, so every process sees the same completion edge
  assign wr_ctrl  = wr_done & (paddr == `STCS_OFF_CTRL);
  assign wr_flags = wr_done & (paddr == `STCS_OFF_FLAGS);
  assign wr_cnt   = wr_done & (paddr == `STCS_OFF_CNT);
  assign wr_cmp   = wr_done & (paddr == `STCS_OFF_CMP);
  assign wr_iclr  = wr_done & (paddr == `STCS_OFF_ICLR);
  assign wr_ien   = wr_done & (paddr == `STCS_OFF_IEN);
  assign rd_flags = rd_done & (paddr == `STCS_OFF_FLAGS);

  // address decode for the setup cycle
  always @* begin
    case (paddr)
      `STCS_OFF_CTRL,
      `STCS_OFF_FLAGS,
      `STCS_OFF_CNT,
      `STCS_OFF_CMP,
      `STCS_OFF_ISTAT,
      `STCS_OFF_ICLR,
      `STCS_OFF_IEN: addr_ok = 1'b1;
      default:       addr_ok = 1'b0;
    endcase
  end

  // read mux, sampled in setup so flag arming sees exactly what software read
  always @* begin
    rdata_next = `STCS_DATA_ZERO;
    case (paddr)
      `STCS_OFF_CTRL:  rdata_next[`STCS_CTRL_W-1:0] = ctrl_reg;
      `STCS_OFF_FLAGS: rdata_next[`STCS_NFLAG-1:0] = flag_vec;
      `STCS_OFF_CNT:   rdata_next[`STCS_CNT_BITS] = combined_16bit_counter;
      `STCS_OFF_CMP:   rdata_next[`STCS_CNT_BITS] = {high_half_compare_value_reg,
                                           low_half_compare_value_reg};
      `STCS_OFF_ISTAT: rdata_next[`STCS_NFLAG-1:0] = istat_reg;
      `STCS_OFF_IEN:   rdata_next[`STCS_NFLAG-1:0] = ien_reg;
      default:         rdata_next = `STCS_DATA_ZERO; // iclr reads zero
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `STCS_DATA_ZERO;
    end else begin
      pready  <= setup_ph;
      if (setup_ph) begin
        pslverr <= ~addr_ok;
        prdata  <= pwrite ? `STCS_DATA_ZERO : rdata_next;
      end else if (done) begin
        pslverr <= 1'b0;
        prdata  <= `STCS_DATA_ZERO;
      end
    end
  end

  // ----------------------------------------
  // control, compare and enable registers
  // ----------------------------------------
  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = pwdata[`STCS_CTRL_W-1:0];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg                    <= `STCS_CTRL_RST; // R12
      ien_reg                     <= `STCS_FLAG_RST;
      low_half_compare_value_reg  <= `STCS_CMP_LO_RST;
      high_half_compare_value_reg <= `STCS_CMP_HI_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      if (wr_ien) begin
        ien_reg <= pwdata[`STCS_NFLAG-1:0];
      end
      if (wr_cmp) begin
        low_half_compare_value_reg  <= pwdata[`STCS_LO_BITS];
        high_half_compare_value_reg <= pwdata[`STCS_HI_BITS];
      end
    end
  end

  // ----------------------------------------
  // compare detection
  // ----------------------------------------
  // equality and end-of-range terms, shared by both counting modes
  always @* begin
    low_eq      = (low_half_counter_reg == low_half_compare_value_reg);
    high_eq     = (high_half_counter_reg == high_half_compare_value_reg);
    comb_eq     = low_eq & high_eq;
    low_at_max  = (low_half_counter_reg == `STCS_HALF_MAX);
    high_at_max = (high_half_counter_reg == `STCS_HALF_MAX);
    comb_at_max = low_at_max & high_at_max;
  end

  // ----------------------------------------
  // counter and event detection
  // ----------------------------------------
  // a match is the counter holding the compare value; clearing happens on the
  // following tick, so the matched value is visible for a full count period
  always @* begin
    low_half_counter_next  = low_half_counter_reg;
    high_half_counter_next = high_half_counter_reg;
    low_match_ev  = 1'b0;
    low_wrap_ev   = 1'b0;
    high_match_ev = 1'b0;
    high_wrap_ev  = 1'b0;
    if (wr_cnt) begin
      // software load beats counting, no events from a load
      low_half_counter_next  = pwdata[`STCS_LO_BITS];
      high_half_counter_next = pwdata[`STCS_HI_BITS];
    end else if (tick && mode16) begin
      if (comb_eq && ctrl_reg[`STCS_CTRL_CLRH]) begin
        low_half_counter_next  = `STCS_HALF_ZERO; // R7
        high_half_counter_next = `STCS_HALF_ZERO;
      end else begin
        low_half_counter_next  = comb_inc[`STCS_LO_BITS];
        high_half_counter_next = comb_inc[`STCS_HI_BITS];
        low_wrap_ev  = low_at_max; // R3
        high_wrap_ev = comb_at_max;
      end
    end else if (tick) begin
      if (low_eq && ctrl_reg[`STCS_CTRL_CLRL]) begin
        low_half_counter_next = `STCS_HALF_ZERO; // R5
      end else begin
        low_half_counter_next = low_half_counter_reg + `STCS_HALF_ONE;
        low_wrap_ev = low_at_max; // R3
      end
      if (high_eq && ctrl_reg[`STCS_CTRL_CLRH]) begin
        high_half_counter_next = `STCS_HALF_ZERO; // R8
      end else begin
        high_half_counter_next = high_half_counter_reg + `STCS_HALF_ONE;
        high_wrap_ev = high_at_max;
      end
    end
    // match events fire when a half changes onto its compare value
    if (low_half_counter_next != low_half_counter_reg) begin
      low_match_ev = (low_half_counter_next == low_half_compare_value_reg) & ~wr_cnt; // R1
    end
    if (high_half_counter_next != high_half_counter_reg) begin
      high_match_ev = (high_half_counter_next == high_half_compare_value_reg) & ~wr_cnt;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_half_counter_reg  <= `STCS_HALF_ZERO;
      high_half_counter_reg <= `STCS_HALF_ZERO;
    end else begin
      low_half_counter_reg  <= low_half_counter_next;
      high_half_counter_reg <= high_half_counter_next;
    end
  end

  // event vector in the shared flag layout
  always @* begin
    event_vec = `STCS_FLAG_RST;
    event_vec[`STCS_F_LMATCH] = low_match_ev;
    event_vec[`STCS_F_LWRAP]  = low_wrap_ev;
    event_vec[`STCS_F_HMATCH] = high_match_ev;
    event_vec[`STCS_F_HWRAP]  = high_wrap_ev;
  end

  // ----------------------------------------
  // software-cleared flags
  // ----------------------------------------
  // arming uses the captured read data, i.e. the value software really saw
  genvar gi;
  generate
    for (gi = 0; gi < `STCS_NFLAG; gi = gi + 1) begin : g_flag
      stcs_flag u_flag (
        .clk       (clk),
        .rst_n     (rst_n),
        .set_pulse (event_vec[gi]),
        .rd_as_one (rd_flags & prdata[gi]),
        .wr_access (wr_flags),
        .wr_bit    (pwdata[gi]),
        .flag_reg  (flag_vec[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // interrupt status, clear and enable
  // ----------------------------------------
  // sticky status; write one to clear, a new event in the same cycle wins
  always @* begin
    istat_next = istat_reg;
    if (wr_iclr) begin
      istat_next = istat_reg & ~pwdata[`STCS_NFLAG-1:0];
    end
    istat_next = istat_next | event_vec;
  end

  // ----------------------------------------
  // interrupt outputs
  // ----------------------------------------
  // request levels before the output flops
  always @* begin
    low_ovf_irq_next  = flag_vec[`STCS_F_LWRAP] & ctrl_reg[`STCS_CTRL_OVIEL]; // R6 R12
    high_ovf_irq_next = flag_vec[`STCS_F_HWRAP] & ctrl_reg[`STCS_CTRL_OVIEH]; // R11 R12
    irq_next          = (|(istat_reg & ien_reg)) | low_ovf_irq_next | high_ovf_irq_next; // R12
  end

  // outputs registered: requests follow their causes by one clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_reg    <= `STCS_FLAG_RST;
      irq          <= 1'b0;
      low_ovf_irq  <= 1'b0;
      high_ovf_irq <= 1'b0;
    end else begin
      istat_reg    <= istat_next;
      low_ovf_irq  <= low_ovf_irq_next;
      high_ovf_irq <= high_ovf_irq_next;
      irq          <= irq_next;
    end
  end

endmodule // stcs_top

// file: verification/stcs_sva.sv
// checker for the split timer block, watching only the top module's ports
// assumes one clock domain with an active-low async reset; bound below
module stcs_sva (
  input logic        clk,
  input logic        rst_n,
  input logic        count_tick,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        irq,
  input logic        low_ovf_irq,
  input logic        high_ovf_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // bus steps
  // ----------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  // flag or status moves at the cause edge, the request flop one edge later
  sequence s_cause;
    $past(count_tick, 2) || $past(psel && penable && pwrite && pready, 2);
  endsequence
  sequence s_wr_done;
    $past(psel && penable && pwrite && pready, 2);
  endsequence

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_ready_next;   s_setup |=> pready; endproperty
  property p_ready_only;   pready |-> psel && penable && $past(psel && !penable); endproperty
  property p_err_access;   pslverr |-> pready; endproperty
  property p_rdata_idle;   !pready |-> prdata == 32'h00000000; endproperty
  property p_low_in_irq;   low_ovf_irq |-> irq; endproperty
  property p_high_in_irq;  high_ovf_irq |-> irq; endproperty
  // a request only rises after a count event or a software write
  property p_low_rise;     $rose(low_ovf_irq) |-> s_cause; endproperty
  property p_high_rise;    $rose(high_ovf_irq) |-> s_cause; endproperty
  property p_irq_rise;     $rose(irq) |-> s_cause; endproperty
  // requests only drop on a completed software write
  property p_low_fall;     $fell(low_ovf_irq) |-> s_wr_done; endproperty
  property p_high_fall;    $fell(high_ovf_irq) |-> s_wr_done; endproperty
  property p_irq_fall;     $fell(irq) |-> s_wr_done; endproperty

  a_ready_next:  assert property (p_ready_next) else $error("no ready after setup");
  a_ready_only:  assert property (p_ready_only) else $error("ready outside access");
  a_err_access:  assert property (p_err_access) else $error("error outside access");
  a_rdata_idle:  assert property (p_rdata_idle) else $error("read data not zero idle");
  a_low_in_irq:  assert property (p_low_in_irq) else $error("low request not on irq");
  a_high_in_irq: assert property (p_high_in_irq) else $error("high request not on irq");
  a_low_rise:    assert property (p_low_rise) else $error("low request rose alone");
  a_high_rise:   assert property (p_high_rise) else $error("high request rose alone");
  a_irq_rise:    assert property (p_irq_rise) else $error("irq rose alone");
  a_low_fall:    assert property (p_low_fall) else $error("low request fell alone");
  a_high_fall:   assert property (p_high_fall) else $error("high request fell alone");
  a_irq_fall:    assert property (p_irq_fall) else $error("irq fell alone");
endmodule // stcs_sva

bind stcs_top stcs_sva u_sva (.clk(clk), .rst_n(rst_n), .count_tick(count_tick),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .low_ovf_irq(low_ovf_irq), .high_ovf_irq(high_ovf_irq));

// file: verification/stcs_top_tb.sv
// self-checking bench for the split timer block, driven over apb
// assumes count_tick is a one-cycle strobe on clk and the map header
`include "stcs_map.vh"
module stcs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, count_tick, psel, penable, pwrite, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rdat;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, low_ovf_irq, high_ovf_irq;
  int          errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  wire  [2:0]  req_pins;
  localparam int pin_low  = 0;
  localparam int pin_high = 1;
  localparam int pin_irq  = 2;

  stcs_top dut (.clk(clk), .rst_n(rst_n), .count_tick(count_tick), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .low_ovf_irq(low_ovf_irq), .high_ovf_irq(high_ovf_irq));
  // request pins gathered so the settle task can pick one after its wait
  assign req_pins = {irq, high_ovf_irq, low_ovf_irq};

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      $display("timeout at %0t", $time);
      stop_test;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task stop_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until ready is sampled high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rdat, exp);
  endtask
  task tick(input int n);
    repeat (n) begin
      @(posedge clk) count_tick <= 1'b1;
      @(posedge clk) count_tick <= 1'b0;
    end
  endtask
  // requests are registered, so give them two edges to settle, then look
  task pin(input int idx, input logic exp);
    repeat (2) @(posedge clk);
    chk({31'h0, req_pins[idx]}, {31'h0, exp});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0; count_tick = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h00000000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(`STCS_OFF_CTRL, 32'h00000000);
    rd(`STCS_OFF_FLAGS, 32'h00000000);
    rd(`STCS_OFF_CMP, 32'h0000FFFF);
    rd(`STCS_OFF_IEN, 32'h00000000);
    apb(1'b0, 8'h1C, 32'h00000000);
    chk({31'h0, rerr}, 32'h00000001);
    rd(`STCS_OFF_ICLR, 32'h00000000);
    // low match while low clear is off: counter keeps going
    wr(`STCS_OFF_CMP, 32'h00008002);
    wr(`STCS_OFF_CTRL, 32'h00000020);
    tick(2);
    rd(`STCS_OFF_FLAGS, 32'h00000001);
    tick(1);
    rd(`STCS_OFF_CNT, 32'h00000303);
    // a write disarms, so the next zero write must not clear
    wr(`STCS_OFF_FLAGS, 32'h0000000F);
    wr(`STCS_OFF_FLAGS, 32'h00000000);
    rd(`STCS_OFF_FLAGS, 32'h00000001);
    wr(`STCS_OFF_FLAGS, 32'h00000000);
    rd(`STCS_OFF_FLAGS, 32'h00000000);
    // low wrap with its request enabled
    wr(`STCS_OFF_CTRL, 32'h00000022);
    wr(`STCS_OFF_CNT, 32'h000000FE);
    tick(2);
    pin(pin_low, 1'b1);
    rd(`STCS_OFF_FLAGS, 32'h00000002);
    wr(`STCS_OFF_FLAGS, 32'h00000000);
    pin(pin_low, 1'b0);
    pin(pin_irq, 1'b0);
    // high half cleared on its match in 8-bit mode
    wr(`STCS_OFF_CTRL, 32'h00000024);
    wr(`STCS_OFF_CMP, 32'h00000380);
    wr(`STCS_OFF_CNT, 32'h00000000);
    tick(4);
    rd(`STCS_OFF_CNT, 32'h00000004);
    rd(`STCS_OFF_FLAGS, 32'h00000004);
    wr(`STCS_OFF_FLAGS, 32'h00000000);
    rd(`STCS_OFF_FLAGS, 32'h00000000);
    // low half cleared on its match in 8-bit mode: 0, 1, 2, 0
    wr(`STCS_OFF_CTRL, 32'h00000021);
    wr(`STCS_OFF_CMP, 32'h00008002);
    wr(`STCS_OFF_CNT, 32'h00000000);
    tick(3);
    rd(`STCS_OFF_CNT, 32'h00000300);
    rd(`STCS_OFF_FLAGS, 32'h00000001);
    wr(`STCS_OFF_FLAGS, 32'h00000000);
    rd(`STCS_OFF_FLAGS, 32'h00000000);
    // 16-bit mode passes its match and wraps the high half
    wr(`STCS_OFF_CTRL, 32'h00000038);
    wr(`STCS_OFF_CMP, 32'h0000FFFE);
    wr(`STCS_OFF_CNT, 32'h0000FFFD);
    tick(2);
    rd(`STCS_OFF_CNT, 32'h0000FFFF);
    tick(1);
    pin(pin_high, 1'b1);
    apb(1'b0, `STCS_OFF_FLAGS, 32'h00000000);
    chk(rdat & 32'h00000008, 32'h00000008);
    wr(`STCS_OFF_FLAGS, 32'h00000000);
    pin(pin_high, 1'b0);
    // sticky status: masked, enabled, then cleared
    wr(`STCS_OFF_CTRL, 32'h00000000);
    rd(`STCS_OFF_ISTAT, 32'h0000000F);
    pin(pin_irq, 1'b0);
    wr(`STCS_OFF_IEN, 32'h00000002);
    pin(pin_irq, 1'b1);
    wr(`STCS_OFF_ICLR, 32'h0000000F);
    pin(pin_irq, 1'b0);
    rd(`STCS_OFF_ISTAT, 32'h00000000);
    stop_test;
  end
endmodule // stcs_top_tb
